// *** rtl/dit_pkg.sv ***
// Constants for the drive input terminal function block
package dit_pkg;

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int FC_MIN_WIDTH_MS = 12;
    localparam int FC_MIN_WIDTH_TICKS = FC_MIN_WIDTH_MS / TICK_MS;
    localparam int ALARM_CLEAR_MS = 30;
    localparam int ALARM_CLEAR_TICKS = ALARM_CLEAR_MS / TICK_MS;
    localparam int FC_POWERUP_S = 4;
    localparam int FC_POWERUP_TICKS = FC_POWERUP_S * 1000 / TICK_MS;

    // ------------------------------------------------------------------
    // Terminals and function codes
    // ------------------------------------------------------------------
    localparam int NUM_SLOTS = 5;
    localparam int CODE_W = 5;
    localparam int REF_W = 10;
    localparam logic [CODE_W-1:0] FN_PARAM_LOCK = 5'h0f;
    localparam logic [CODE_W-1:0] FN_ANALOG_SEL = 5'h10;
    localparam logic [CODE_W-1:0] FN_FAULT_CLEAR = 5'h12;
    localparam logic [1:0] FREQ_SRC_ANALOG = 2'h1;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLOT_FN = 8'h04;
    localparam logic [7:0] ADDR_SLOT_POL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_FREQ = 8'h10;
    localparam int CTRL_SCOPE_ALL = 0;
    localparam int CTRL_OP_LOCK = 1;
    localparam int CTRL_SRC_LO = 2;
    localparam logic [3:0] CTRL_RESET = 4'h4;
    localparam logic [24:0] SLOT_FN_RESET = 25'h0;
    localparam logic [4:0] SLOT_POL_RESET = 5'h0;

    typedef enum {
        ST_POWERUP,
        ST_NORMAL,
        ST_CLEARING
    } dit_state_e;

endpackage

// *** rtl/dit_input_functions.sv ***
// Logic input terminal functions: parameter lock, analog select, fault clear
// ----------------------------------------------------------------------
// Functional notes
// - Lock input on refuses parameter edits
// - Lock input off allows edits again
// - Scope setting decides whether frequency locks
// - Operator lock works without lock terminal
// - Select on uses current, off voltage
// - Analog refs used only with analog source
// - No select terminal means summed references
// - Any function assignable to any slot
// - Reset operation clears trip state
// - Reset runs when clear input on-off
// - Alarm drops within latency after onset
// - Clear on: motor off, trip cleared
// - Clear held at power-up: comm error (never raised: pwr_held drops at the first tick, in the same cycle samp first loads)
// - Stop key resets only with alarm
// - Clear terminal forced to normally open
// - Power-on performs same reset operation
// - Clear while running makes motor coast
// - Drive resumes at once if run active
// ----------------------------------------------------------------------
`timescale 1ns/10ps

module dit_input_functions
    import dit_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_SLOTS-1:0] term_i,
    input wire logic [REF_W-1:0] volt_ref_i,
    input wire logic [REF_W-1:0] current_ref_input_i,
    input wire logic fault_event_i,
    input wire logic run_cmd_i,
    input wire logic stop_key_i,
    input wire logic op_key_i,
    input wire logic remote_op_present_i,
    input wire logic edit_req_i,
    input wire logic edit_is_freq_i,
    output logic edit_grant_o,
    output logic alarm_o,
    output logic motor_enable_o,
    output logic coast_o,
    output logic powerup_reset_o,
    output logic comm_err_o,
    output logic [REF_W:0] freq_cmd_o,
    output logic freq_cmd_valid_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] tick_cnt;
        logic tick;
        logic [NUM_SLOTS-1:0] samp;
        logic [3:0] ctrl;
        logic [24:0] slot_fn;
        logic [4:0] slot_pol;
        dit_state_e state;
        logic [15:0] width_cnt;
        logic width_ok;
        logic [15:0] pwr_cnt;
        logic pwr_held;
        logic trip;
        logic motor_en;
        logic coast;
        logic por;
        logic comm_err;
        logic grant;
        logic [REF_W:0] freq;
        logic freq_valid;
        logic ack;
        logic [31:0] rdata;
    } dit_regs_s;

    dit_regs_s r;
    dit_regs_s next_r;

    // Mask of slots assigned to a given function code
    function automatic logic [NUM_SLOTS-1:0] slot_match(
        input logic [24:0] fn,
        input logic [CODE_W-1:0] code
    );
        logic [NUM_SLOTS-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            m[i] = (fn[i*CODE_W +: CODE_W] == code);
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Decoded terminal functions
    // ------------------------------------------------------------------
    logic [NUM_SLOTS-1:0] lock_slots;
    logic [NUM_SLOTS-1:0] sel_slots;
    logic [NUM_SLOTS-1:0] fc_slots;
    logic lock_on;
    logic sel_on;
    logic sel_assigned;
    logic fc_on;
    logic [NUM_SLOTS-1:0] pol_eff;
    logic [NUM_SLOTS-1:0] live;
    logic wb_req;

    always_comb begin
        lock_slots = slot_match(r.slot_fn, FN_PARAM_LOCK);
        sel_slots = slot_match(r.slot_fn, FN_ANALOG_SEL);
        fc_slots = slot_match(r.slot_fn, FN_FAULT_CLEAR);
        pol_eff = r.slot_pol & ~fc_slots;
        live = r.samp ^ pol_eff;
        lock_on = |(live & lock_slots);
        sel_on = |(live & sel_slots);
        sel_assigned = |sel_slots;
        fc_on = |(live & fc_slots);
        wb_req = wb_cyc_i & wb_stb_i & ~r.ack;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic reset_op;
        logic locked;
        reset_op = 1'b0;
        locked = 1'b0;
        next_r = r;
        next_r.tick = 1'b0;
        next_r.por = 1'b0;

        // Millisecond timebase; terminals only move on its edge
        if (r.tick_cnt >= 32'(TICK_CYCLES_P - 1)) begin
            next_r.tick_cnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.tick_cnt = r.tick_cnt + 32'h1;
        end
        if (r.tick) begin
            next_r.samp = term_i;
        end

        // Fault clear sequence
        case (r.state)
            ST_POWERUP: begin
                reset_op = 1'b1;
                next_r.state = ST_NORMAL;
            end
            ST_NORMAL: begin
                if (fc_on) begin
                    next_r.state = ST_CLEARING;
                    next_r.width_cnt = '0;
                    next_r.width_ok = 1'b0;
                end else if (stop_key_i && r.trip) begin
                    reset_op = 1'b1;
                end
            end
            ST_CLEARING: begin
                next_r.por = 1'b1;
                next_r.trip = 1'b0;
                if (r.tick && r.width_cnt != 16'hffff) begin
                    next_r.width_cnt = r.width_cnt + 16'h1;
                end
                if (r.width_cnt >= 16'(FC_MIN_WIDTH_TICKS)) begin
                    next_r.width_ok = 1'b1;
                end
                if (!fc_on) begin
                    next_r.state = ST_NORMAL;
                    // Short glitches only clear, no full reset pass
                    // A pulse of exactly the minimum width still counts
                    reset_op = r.width_ok
                        | (r.width_cnt >= 16'(FC_MIN_WIDTH_TICKS));
                end
            end
            default: begin
                next_r.state = ST_POWERUP;
            end
        endcase

        if (reset_op) begin
            next_r.trip = 1'b0;
            next_r.por = 1'b1;
        end
        if (fault_event_i) begin
            next_r.trip = 1'b1;
        end

        // Clear input held since power-up
        if (r.pwr_held && r.tick) begin
            if (!fc_on) begin
                next_r.pwr_held = 1'b0;
            end else if (r.pwr_cnt != 16'hffff) begin
                next_r.pwr_cnt = r.pwr_cnt + 16'h1;
            end
        end
        if (!fc_on && op_key_i) begin
            next_r.comm_err = 1'b0;
        end
        if (r.pwr_held && remote_op_present_i
                && r.pwr_cnt >= 16'(FC_POWERUP_TICKS)) begin
            next_r.comm_err = 1'b1;
        end

        // Motor drive; no restart interlock after reset
        next_r.motor_en = run_cmd_i & ~next_r.trip
            & (next_r.state != ST_CLEARING);
        next_r.coast = (next_r.state == ST_CLEARING) & r.motor_en;
        if (r.coast && next_r.state == ST_CLEARING) begin
            next_r.coast = 1'b1;
        end

        // Parameter edit gate
        locked = lock_on | r.ctrl[CTRL_OP_LOCK];
        next_r.grant = edit_req_i & (~locked
            | (edit_is_freq_i & ~r.ctrl[CTRL_SCOPE_ALL]));

        // Frequency command source
        next_r.freq_valid = r.ctrl[CTRL_SRC_LO +: 2] == FREQ_SRC_ANALOG;
        if (!next_r.freq_valid) begin
            next_r.freq = '0;
        end else if (!sel_assigned) begin
            next_r.freq = {1'b0, volt_ref_i}
                + {1'b0, current_ref_input_i};
        end else if (sel_on) begin
            next_r.freq = {1'b0, current_ref_input_i};
        end else begin
            next_r.freq = {1'b0, volt_ref_i};
        end

        // Wishbone slave, one wait state
        next_r.ack = wb_req;
        next_r.rdata = '0;
        if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        next_r.ctrl = wb_dat_i[3:0];
                    end
                end
                ADDR_SLOT_FN: begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b] && b < 3) begin
                            next_r.slot_fn[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                        end
                    end
                    if (wb_sel_i[3]) begin
                        next_r.slot_fn[24] = wb_dat_i[24];
                    end
                end
                ADDR_SLOT_POL: begin
                    if (wb_sel_i[0]) begin
                        next_r.slot_pol = wb_dat_i[4:0];
                    end
                end
                default: begin
                    next_r.ctrl = r.ctrl;
                end
            endcase
        end else if (wb_req) begin
            case (wb_adr_i)
                ADDR_CTRL: next_r.rdata = {28'h0, r.ctrl};
                ADDR_SLOT_FN: next_r.rdata = {7'h0, r.slot_fn};
                ADDR_SLOT_POL: next_r.rdata = {27'h0, pol_eff};
                ADDR_STATUS: begin
                    next_r.rdata = {24'h0, sel_assigned, sel_on, fc_on,
                        lock_on, r.comm_err, r.coast, r.motor_en, r.trip};
                end
                ADDR_FREQ: begin
                    next_r.rdata = {20'h0, r.freq_valid, r.freq};
                end
                default: next_r.rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r.tick_cnt <= '0;
            r.tick <= 1'b0;
            r.samp <= '0;
            r.ctrl <= CTRL_RESET;
            r.slot_fn <= SLOT_FN_RESET;
            r.slot_pol <= SLOT_POL_RESET;
            r.state <= ST_POWERUP;
            r.width_cnt <= '0;
            r.width_ok <= 1'b0;
            r.pwr_cnt <= '0;
            r.pwr_held <= 1'b1;
            r.trip <= 1'b0;
            r.motor_en <= 1'b0;
            r.coast <= 1'b0;
            r.por <= 1'b1;
            r.comm_err <= 1'b0;
            r.grant <= 1'b0;
            r.freq <= '0;
            r.freq_valid <= 1'b0;
            r.ack <= 1'b0;
            r.rdata <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign edit_grant_o = r.grant;
    assign alarm_o = r.trip;
    assign motor_enable_o = r.motor_en;
    assign coast_o = r.coast;
    assign powerup_reset_o = r.por;
    assign comm_err_o = r.comm_err;
    assign freq_cmd_o = r.freq;
    assign freq_cmd_valid_o = r.freq_valid;

endmodule // dit_input_functions

// *** verification/dit_checker.sv ***
// Port assertions for the drive input terminal functions
`timescale 1ns/10ps

module dit_checker
    import dit_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic fault_event_i,
    input wire logic run_cmd_i,
    input wire logic stop_key_i,
    input wire logic edit_req_i,
    input wire logic edit_grant_o,
    input wire logic alarm_o,
    input wire logic motor_enable_o,
    input wire logic coast_o,
    input wire logic powerup_reset_o
);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_grant_needs_req: assert property (!edit_req_i |=> !edit_grant_o)
        else $error("edit granted without request");
    a_clear_quiet: assert property (powerup_reset_o [*3]
        |-> !$past(alarm_o) && !$past(motor_enable_o))
        else $error("output during clear");
    a_coast_off: assert property (coast_o |-> !motor_enable_o)
        else $error("motor driven while coasting");
    a_stop_idle: assert property (stop_key_i && !alarm_o
        && !powerup_reset_o && !fault_event_i
        |=> !powerup_reset_o ##1 !powerup_reset_o)
        else $error("stop key reset without alarm");
    a_stop_clears: assert property (stop_key_i && alarm_o && !fault_event_i
        |-> ##[1:3] !alarm_o) else $error("stop key left alarm");
    a_resume_run: assert property ($fell(powerup_reset_o) && run_cmd_i
        |-> ##[0:3] motor_enable_o) else $error("no resume after reset");

    c_coast: cover property (coast_o);
    c_stop_alarm: cover property (stop_key_i && alarm_o);
    c_refused: cover property (edit_req_i ##1 edit_req_i && !edit_grant_o);
endmodule // dit_checker

bind dit_input_functions dit_checker #(.TICK_CYCLES_P(TICK_CYCLES_P))
    u_chk (.*);

// *** verification/dit_term_model.sv ***
// Switch contacts on the logic input terminal strip
`timescale 1ns/10ps

module dit_term_model
    import dit_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk_sys_i,
    output logic [NUM_SLOTS-1:0] term_o
);
    initial term_o = '0;

    // Level contacts such as lock and source select
    task automatic set_level(input int slot, input logic v);
        @(posedge clk_sys_i);
        term_o[slot] <= v;
    endtask

    // Clear pulse in whole ticks, never below the minimum width
    task automatic pulse(input int slot, input int ticks);
        int t;
        t = (ticks < FC_MIN_WIDTH_TICKS) ? FC_MIN_WIDTH_TICKS : ticks;
        set_level(slot, 1'h1);
        repeat (t * TICK_CYCLES_P) @(posedge clk_sys_i);
        term_o[slot] <= 1'h0;
    endtask
endmodule // dit_term_model

// *** verification/tb.sv ***
// Self-checking bench for the drive input terminal functions
`timescale 1ns/10ps

module tb;
    import dit_pkg::*;
    localparam int TK = 10;
    logic clk_sys_i = 1'h0;
    logic resetn_i = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    wire logic [NUM_SLOTS-1:0] term_i;
    logic [REF_W-1:0] volt_ref_i = 10'h0;
    logic [REF_W-1:0] current_ref_input_i = 10'h0;
    logic fault_event_i = 1'h0;
    logic run_cmd_i = 1'h0;
    logic stop_key_i = 1'h0;
    logic op_key_i = 1'h0;
    logic remote_op_present_i = 1'h0;
    logic edit_req_i = 1'h0;
    logic edit_is_freq_i = 1'h0;
    logic edit_grant_o, alarm_o, motor_enable_o, coast_o;
    logic powerup_reset_o, comm_err_o, freq_cmd_valid_o;
    logic [REF_W:0] freq_cmd_o;
    logic [31:0] seed = 32'h50d6;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int compares = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    dit_input_functions #(.TICK_CYCLES_P(TK)) DUT (.*);
    dit_term_model #(.TICK_CYCLES_P(TK)) mdl (
        .clk_sys_i(clk_sys_i),
        .term_o(term_i)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Classic cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int i;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++) @(posedge clk_sys_i);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (i == 20) begin
            n_errors++;
            give_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'h0, a, 32'h0);
    endtask

    // Read results matched against the oldest note
    always @(posedge clk_sys_i) begin
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
            check("wb_dat_o", wb_dat_o, exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        int i;
        logic lk, op, sc, fq;
        logic [9:0] v, c;
        cyc(2);
        resetn_i <= 1'h1;
        rd(ADDR_CTRL, {28'h0, CTRL_RESET});
        rd(ADDR_SLOT_FN, 32'h0);
        rd(8'h20, 32'h0);
        wb(1'h1, 8'h20, 32'hffff_ffff);
        wb(1'h1, ADDR_SLOT_FN, {17'h0, FN_FAULT_CLEAR, FN_ANALOG_SEL,
                                FN_PARAM_LOCK});
        wb(1'h1, ADDR_SLOT_POL, 32'h4);
        rd(ADDR_SLOT_POL, 32'h0);
        edit_req_i <= 1'h1;
        for (i = 0; i < 16; i++) begin
            {lk, op, sc, fq} = 4'(i);
            wb(1'h1, ADDR_CTRL, {28'h0, 2'h1, op, sc});
            mdl.set_level(0, lk);
            edit_is_freq_i <= fq;
            cyc(2 * TK);
            check("edit_grant_o", {31'h0, edit_grant_o},
                  {31'h0, !(lk | op) | (fq & !sc)});
        end
        edit_req_i <= 1'h0;
        mdl.set_level(0, 1'h0);
        wb(1'h1, ADDR_CTRL, 32'h4);
        for (i = 0; i < 2; i++) begin
            v = 10'(xs());
            c = 10'(xs());
            volt_ref_i <= v;
            current_ref_input_i <= c;
            mdl.set_level(1, i[0]);
            cyc(2 * TK);
            rd(ADDR_FREQ, {20'h0, 1'h1, 1'h0, i[0] ? c : v});
        end
        mdl.set_level(1, 1'h0);
        wb(1'h1, ADDR_CTRL, 32'h0);
        cyc(4);
        check("valid", {31'h0, freq_cmd_valid_o}, 32'h0);
        wb(1'h1, ADDR_CTRL, 32'h4);
        wb(1'h1, ADDR_SLOT_FN, {7'h0, FN_FAULT_CLEAR, 20'h0});
        cyc(2 * TK);
        rd(ADDR_FREQ, {20'h0, 1'h1, {1'h0, v} + {1'h0, c}});
        run_cmd_i <= 1'h1;
        // Trip first, then clear while running to see the coast
        for (i = 0; i < 2; i++) begin
            fault_event_i <= !i[0];
            cyc(1);
            fault_event_i <= 1'h0;
            cyc(4);
            rd(ADDR_STATUS, i[0] ? 32'h2 : 32'h1);
            fork
                mdl.pulse(4, 12);
                begin
                    cyc(6 * TK);
                    rd(ADDR_STATUS, i[0] ? 32'h24 : 32'h20);
                end
            join
            cyc(2 * TK);
            rd(ADDR_STATUS, 32'h2);
        end
        // Stop key without and with a pending alarm
        for (i = 0; i < 2; i++) begin
            fault_event_i <= i[0];
            cyc(1);
            fault_event_i <= 1'h0;
            cyc(3);
            stop_key_i <= 1'h1;
            cyc(1);
            stop_key_i <= 1'h0;
            cyc(6);
            rd(ADDR_STATUS, 32'h2);
        end
        give_verdict();
    end
endmodule // tb
